//--- src/sgs_pkg.sv
package sgs_pkg;

    // **************************************************
    // Register map, byte addresses on APB
    // **************************************************
    localparam logic [7:0] SGS_OFF_CTRL   = 8'h00;  // Force enable, used groups
    localparam logic [7:0] SGS_OFF_FORCE  = 8'h04;  // Forced group selector
    localparam logic [7:0] SGS_OFF_REMOTE = 8'h08;  // Remote change request
    localparam logic [7:0] SGS_OFF_LOCAL  = 8'h0c;  // Local panel change request
    localparam logic [7:0] SGS_OFF_STATUS = 8'h10;  // Active group, enabled mask, failures

    // **************************************************
    // Field positions
    // **************************************************
    localparam int SGS_CTRL_FORCE_BIT = 0;   // force_override_enable
    localparam int SGS_CTRL_USED_LSB  = 4;   // Used-groups code, 3 bits
    localparam int SGS_ST_ACT_LSB     = 0;   // Active group code, 4 bits
    localparam int SGS_ST_EN_LSB      = 8;   // Enabled group mask, 8 bits
    localparam int SGS_ST_FAIL_LSB    = 16;  // Sticky failures, 3 bits

    // **************************************************
    // Widths and reset values
    // **************************************************
    localparam int         SGS_NGRP        = 8;
    localparam logic [3:0] SGS_GRP_NONE    = 4'h0;  // Selector value "no group"
    localparam logic [3:0] SGS_GRP_ONE     = 4'h1;  // group_one code
    localparam logic [2:0] SGS_USED_RST    = 3'h0;  // group_one only
    localparam logic [7:0] SGS_MASK_ONE    = 8'h01;
    localparam logic [2:0] SGS_FAIL_NC     = 3'h1;  // Group not enabled
    localparam logic [2:0] SGS_FAIL_FORCE  = 3'h2;  // Forcing not enabled
    localparam logic [2:0] SGS_FAIL_LOWPRI = 3'h4;  // Blocked by held level

    // **************************************************
    // Bus carriers
    // **************************************************
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } sgs_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } sgs_apb_rsp_t;

endpackage : sgs_pkg

//--- src/sgs_selector.sv
// What this block does
// - Force accepted only if enabled group, forcing on
// - Forcing lets link or panel pick groups
// - Held levels retake control once forcing released
// - Active group readable, group one after reset
// - Forced selector: zero none, one..eight groups
// - Forced selection acts as latching pulse
// - Last forced group stays until new activation
// - Force enable resets off, overrides automatic control
// - Used-groups code enables groups one..code+1
// - Newly enabled group loads default parameters
// - Remote request refused below held higher level
// - Eight inputs, fixed priority, group one highest
// - Held level blocks all lower-priority requests
// - Held group eight level blocks nothing
// - Pulsed group stays until next activation; any held level takes it back next edge
// - Only group one by default, logic idle
// - Request for disabled group rejected and flagged
`timescale 1ns/1ps
`default_nettype none

module sgs_selector
    import sgs_pkg::*;
(
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         sys_rst_i,
    // APB slave
    input  wire sgs_apb_req_t apb_req_i,
    output var  sgs_apb_rsp_t apb_rsp_o,
    // Group activation inputs, bit 0 is group_one
    input  wire logic [7:0]   grp_act_i,
    // Selection results
    output logic [3:0]        active_grp_o,
    output logic [7:0]        active_onehot_o,
    output logic [7:0]        grp_enabled_o,
    output logic [7:0]        defaults_load_o,
    output logic              req_fail_o,
    output logic              force_active_o
);

    // **************************************************
    // Helper functions
    // **************************************************

    // Group code 1..8 to one-hot; zero or out of range gives none
    function automatic logic [7:0] code_to_oh(input logic [3:0] code);
        logic [7:0] oh;
        oh = 8'h00;
        if (code != SGS_GRP_NONE && code <= 4'h8) begin
            oh = 8'h01 << (code - 4'h1);
        end
        return oh;
    endfunction : code_to_oh

    // Highest-priority (lowest index) set bit as a group code
    function automatic logic [3:0] pick_first(input logic [7:0] mask);
        logic [3:0] code;
        code = SGS_GRP_NONE;
        for (int i = SGS_NGRP - 1; i >= 0; i--) begin
            if (mask[i]) begin
                code = 4'(i + 1);
            end
        end
        return code;
    endfunction : pick_first

    // Used-groups code to enabled mask, group_one always on
    function automatic logic [7:0] used_to_mask(input logic [2:0] used);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < SGS_NGRP; i++) begin
            if (3'(i) <= used) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : used_to_mask

    // **************************************************
    // State
    // **************************************************
    logic [7:0]   act_prev_r;           // Inputs one cycle ago
    logic [3:0]   active_r;             // Active group code
    logic [3:0]   active_nxt;
    logic         force_en_r;           // force_override_enable
    logic [2:0]   used_r;               // Used-groups code
    logic [3:0]   force_sel_r;          // Last forced selector value
    logic [3:0]   remote_r;             // Last remote request value
    logic [3:0]   local_r;              // Last local panel request value
    logic [2:0]   fail_r;               // Sticky failure causes
    logic [7:0]   en_prev_r;            // Enabled mask one cycle ago
    logic [7:0]   defload_r;            // Default-load pulses
    logic         fail_pulse_r;         // One-cycle failure pulse
    sgs_apb_rsp_t rsp_r;                // Registered APB answer

    // **************************************************
    // APB decode
    // **************************************************
    // Transfers finish in the access phase, so every write lands on
    // the same edge that ends the bus transfer
    wire logic       setup_ph   = apb_req_i.psel & ~apb_req_i.penable;
    wire logic       xfer_done  = apb_req_i.psel & apb_req_i.penable & rsp_r.pready;
    wire logic       wr_fire    = xfer_done & apb_req_i.pwrite;
    wire logic [7:0] addr       = apb_req_i.paddr;
    wire logic [3:0] wcode      = apb_req_i.pwdata[3:0];
    wire logic       hit_ctrl   = (addr == SGS_OFF_CTRL);
    wire logic       hit_force  = (addr == SGS_OFF_FORCE);
    wire logic       hit_remote = (addr == SGS_OFF_REMOTE);
    wire logic       hit_local  = (addr == SGS_OFF_LOCAL);
    wire logic       hit_status = (addr == SGS_OFF_STATUS);
    wire logic       addr_ok    = hit_ctrl | hit_force | hit_remote | hit_local | hit_status;

    // Write strobes per register
    wire logic wr_ctrl   = wr_fire & hit_ctrl;
    wire logic wr_force  = wr_fire & hit_force;
    wire logic wr_remote = wr_fire & hit_remote;
    wire logic wr_local  = wr_fire & hit_local;
    wire logic wr_status = wr_fire & hit_status;

    // **************************************************
    // Input classification
    // **************************************************
    // A level seen on two edges in a row counts as held (static);
    // a rising edge counts as a pulse activation.
    wire logic [7:0] en_mask  = used_to_mask(used_r);
    wire logic [7:0] in_edge  = grp_act_i & ~act_prev_r;
    wire logic [7:0] held     = grp_act_i & act_prev_r & en_mask;
    wire logic       idle     = (en_mask == SGS_MASK_ONE);
    // Limitation: a held level re-requests on every edge, so a group
    // picked by a pulse or a request above a held group stays only
    // until the next edge, when the held group takes the selection back

    // Blocked when any higher-priority group is held; group eight's
    // level sits above nothing, so it never blocks anyone
    wire logic [7:0] blocked;
    for (genvar g = 0; g < SGS_NGRP; g++) begin : g_block
        if (g == 0) begin : g_top
            assign blocked[g] = 1'b0;
        end else begin : g_rest
            assign blocked[g] = |held[g-1:0];
        end
    end

    // **************************************************
    // Request vectors
    // **************************************************
    // Code zero or above eight gives an empty request vector
    wire logic [7:0] force_oh  = wr_force  ? code_to_oh(wcode) : 8'h00;
    wire logic [7:0] remote_oh = wr_remote ? code_to_oh(wcode) : 8'h00;
    wire logic [7:0] local_oh  = wr_local  ? code_to_oh(wcode) : 8'h00;

    // While forcing, link and panel requests are forced selections
    wire logic [7:0] frc_req   = force_oh | remote_oh | local_oh;
    wire logic [7:0] frc_ok    = frc_req & en_mask;

    // Automatic path: input pulses, held levels, remote request
    wire logic [7:0] rem_ok    = remote_oh & en_mask & ~blocked;
    wire logic [7:0] auto_req  = ((in_edge | held) & en_mask) | rem_ok;
    wire logic [7:0] auto_pick = auto_req & ~blocked;

    // Chosen group, highest priority among same-cycle requests
    wire logic [3:0] pick_frc  = pick_first(frc_ok);
    wire logic [3:0] pick_auto = pick_first(auto_pick);

    // **************************************************
    // Failure causes
    // **************************************************
    // Not-configured: any request naming a disabled group
    wire logic f_nc  = |((in_edge | frc_req) & ~en_mask);
    // Force refused: forcing selector or panel used with forcing off
    wire logic f_frc = ~force_en_r & (|(force_oh | local_oh));
    // Lower priority: pulse or remote request under a held level
    wire logic f_lp  = ~force_en_r & (|((in_edge | remote_oh) & en_mask & blocked));
    wire logic [2:0] fail_set = (f_nc ? SGS_FAIL_NC : 3'h0)
                              | (f_frc ? SGS_FAIL_FORCE : 3'h0)
                              | (f_lp ? SGS_FAIL_LOWPRI : 3'h0);

    // **************************************************
    // Next active group
    // **************************************************
    // Order: idle, then forcing, then automatic requests, then the
    // fall-back when the active group is no longer enabled
    always_comb begin
        active_nxt = active_r;
        if (idle) begin
            // Selection logic idle with only group_one in use
            active_nxt = SGS_GRP_ONE;
        end else if (force_en_r) begin
            // Forced selection latches; automatic path ignored
            if (pick_frc != SGS_GRP_NONE) begin
                active_nxt = pick_frc;
            end
        end else if (pick_auto != SGS_GRP_NONE) begin
            // Held levels retake control as soon as forcing drops
            active_nxt = pick_auto;
        end else if ((code_to_oh(active_r) & en_mask) == 8'h00) begin
            // Active group was disabled: fall back to group_one
            active_nxt = SGS_GRP_ONE;
        end
    end

    // **************************************************
    // Read data mux
    // **************************************************
    logic [31:0] rd_data;
    always_comb begin
        rd_data = 32'h0;
        if (hit_ctrl) begin
            rd_data[SGS_CTRL_FORCE_BIT]         = force_en_r;
            rd_data[SGS_CTRL_USED_LSB +: 3]     = used_r;
        end else if (hit_force) begin
            rd_data[3:0] = force_sel_r;
        end else if (hit_remote) begin
            rd_data[3:0] = remote_r;
        end else if (hit_local) begin
            rd_data[3:0] = local_r;
        end else if (hit_status) begin
            rd_data[SGS_ST_ACT_LSB +: 4]  = active_r;
            rd_data[SGS_ST_EN_LSB +: 8]   = en_mask;
            rd_data[SGS_ST_FAIL_LSB +: 3] = fail_r;
        end
    end

    // **************************************************
    // APB answer: zero wait states, ready in the access phase
    // **************************************************
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rsp_r <= '0;
        end else begin
            rsp_r.pready  <= setup_ph;
            // Only unmapped offsets fail; mapped writes always complete
            rsp_r.pslverr <= setup_ph & ~addr_ok;
            rsp_r.prdata  <= setup_ph ? rd_data : 32'h0;
        end
    end

    // **************************************************
    // Settings registers
    // **************************************************
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            force_en_r <= 1'b0;
            used_r     <= SGS_USED_RST;
        end else if (wr_ctrl) begin
            // Write bits outside the two fields are ignored
            // Stays set until software writes it back to zero
            force_en_r <= apb_req_i.pwdata[SGS_CTRL_FORCE_BIT];
            used_r     <= apb_req_i.pwdata[SGS_CTRL_USED_LSB +: 3];
        end
    end

    // Selector values kept for read-back, out-of-range codes dropped
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            force_sel_r <= SGS_GRP_NONE;
            remote_r    <= SGS_GRP_NONE;
            local_r     <= SGS_GRP_NONE;
        end else begin
            if (wr_force && wcode <= 4'h8) begin
                force_sel_r <= wcode;
            end
            if (wr_remote && wcode <= 4'h8) begin
                remote_r <= wcode;
            end
            if (wr_local && wcode <= 4'h8) begin
                local_r <= wcode;
            end
        end
    end

    // **************************************************
    // Active group and input history
    // **************************************************
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            active_r   <= SGS_GRP_ONE;
            act_prev_r <= 8'h00;
        end else begin
            active_r   <= active_nxt;
            act_prev_r <= grp_act_i;
        end
    end

    // **************************************************
    // Failure flags: set wins over a same-cycle clear
    // **************************************************
    // Failure pulse rises on the edge that saw any cause
    wire logic [2:0] fail_clr = wr_status ? apb_req_i.pwdata[SGS_ST_FAIL_LSB +: 3] : 3'h0;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            fail_r       <= 3'h0;
            fail_pulse_r <= 1'b0;
        end else begin
            fail_r       <= (fail_r & ~fail_clr) | fail_set;
            fail_pulse_r <= |fail_set;
        end
    end

    // **************************************************
    // Default-parameter load on newly enabled groups
    // **************************************************
    // One pulse per group on its 0->1 enable transition; the
    // parameter store outside does the actual loading.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            en_prev_r <= SGS_MASK_ONE;
            defload_r <= 8'h00;
        end else begin
            en_prev_r <= en_mask;
            defload_r <= en_mask & ~en_prev_r;
        end
    end

    // **************************************************
    // Outputs, all from flip-flops
    // **************************************************
    // One-hot view follows the next value so it lines up with active_r
    logic [7:0] active_oh_r;       // One-hot copy of the active group
    logic [7:0] grp_en_r;          // Enabled mask as seen outside
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            active_oh_r <= SGS_MASK_ONE;
            grp_en_r    <= SGS_MASK_ONE;
        end else begin
            active_oh_r <= code_to_oh(active_nxt);
            grp_en_r    <= en_mask;
        end
    end

    assign apb_rsp_o       = rsp_r;
    assign active_grp_o    = active_r;
    assign active_onehot_o = active_oh_r;
    assign grp_enabled_o   = grp_en_r;
    assign defaults_load_o = defload_r;
    assign req_fail_o      = fail_pulse_r;
    assign force_active_o  = force_en_r;

endmodule : sgs_selector

`default_nettype wire

//--- verification/sgs_selector_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checker for the group selector
// ****
module sgs_selector_chk
    import sgs_pkg::*;
(
    // Clock and reset
    input wire logic         clock_i,
    input wire logic         sys_rst_i,
    // Bus and activation inputs
    input wire sgs_apb_req_t apb_req_i,
    input wire logic [7:0]   grp_act_i,
    // Design outputs
    input wire sgs_apb_rsp_t apb_rsp_o,
    input wire logic [3:0]   active_grp_o,
    input wire logic [7:0]   active_onehot_o,
    input wire logic [7:0]   grp_enabled_o,
    input wire logic [7:0]   defaults_load_o,
    input wire logic         req_fail_o,
    input wire logic         force_active_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // Setup phase of a transfer
    sequence setup_s;
        apb_req_i.psel && !apb_req_i.penable;
    endsequence
    // Completed write of a real group code to the forced selector
    sequence force_wr_s;
        apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready && apb_req_i.pwrite
            && apb_req_i.paddr == SGS_OFF_FORCE && apb_req_i.pwdata[3:0] inside {[1:8]};
    endsequence
    onehot_match_a: assert property (active_onehot_o == (8'h01 << (active_grp_o - 4'h1)))
        else $error("one-hot view differs from active group");
    grp_code_a: assert property (active_grp_o inside {[4'h1:4'h8]})
        else $error("active group code out of range");
    bus_ready_a: assert property (setup_s |=> apb_rsp_o.pready)
        else $error("no ready one cycle after setup");
    ready_single_a: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready)
        else $error("ready held beyond one cycle");
    force_hold_a: assert property (force_active_o && !apb_req_i.psel |=> $stable(active_grp_o))
        else $error("group changed by inputs while forcing");
    force_refuse_a: assert property (force_wr_s ##0 !force_active_o |-> ##[1:2] req_fail_o)
        else $error("refused force not flagged");
    defaults_new_a: assert property (defaults_load_o == (grp_enabled_o & ~$past(grp_enabled_o)))
        else $error("default load differs from newly enabled groups");
    single_idle_a: assert property ((grp_enabled_o == SGS_MASK_ONE) [*3] |-> active_grp_o == SGS_GRP_ONE)
        else $error("group one not active with single group");
    top_wins_a: assert property (grp_act_i[0] && !force_active_o |=> active_grp_o == SGS_GRP_ONE)
        else $error("group one input did not win");
endmodule : sgs_selector_chk

bind sgs_selector sgs_selector_chk u_chk (.clock_i, .sys_rst_i, .apb_req_i, .grp_act_i, .apb_rsp_o,
    .active_grp_o, .active_onehot_o, .grp_enabled_o, .defaults_load_o, .req_fail_o, .force_active_o);
`default_nettype wire

//--- verification/sgs_act_src.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Digital inputs and internal logic model
// ****
module sgs_act_src (
    // Clock
    input  wire logic  clock_i,
    // Activation lines toward the selector
    output logic [7:0] grp_act_o
);
    logic [7:0] level_r;  // Held static levels
    // Idle: nothing requested
    initial begin
        level_r   = 8'h00;
        grp_act_o = 8'h00;
    end
    // One-cycle pulse riding on the held levels
    task automatic pulse(input logic [7:0] m);
        @(posedge clock_i);
        grp_act_o <= level_r | m;
        @(posedge clock_i);
        grp_act_o <= level_r;
    endtask : pulse
    // Static level, stays until replaced
    task automatic hold(input logic [7:0] m);
        @(posedge clock_i);
        level_r   <= m;
        grp_act_o <= m;
    endtask : hold
endmodule : sgs_act_src
`default_nettype wire

//--- verification/test_setting_group_selector.sv
`timescale 1ns/1ps
`default_nettype none
module test_setting_group_selector
    import sgs_pkg::*;
;
    // ****
    // Signals and table
    // ****
    typedef struct packed {
        logic [2:0] used;  // Used-groups code
        logic [7:0] act;   // Pulsed inputs
        logic [3:0] exp;   // Expected active group
    } sgs_row_t;
    logic         clock_i;
    logic         sys_rst_i;
    sgs_apb_req_t req;
    sgs_apb_rsp_t rsp;
    logic [7:0]   act, onehot, en, dload;
    logic [3:0]   grp;
    logic         fail, frc, e;
    logic [31:0]  q;
    int           err_count, samples_checked, cyc;
    sgs_row_t     rows [7] = '{'{3'h7, 8'h04, 4'h3}, '{3'h7, 8'h80, 4'h8}, '{3'h7, 8'h0a, 4'h2},
                               '{3'h2, 8'h10, 4'h2}, '{3'h0, 8'h04, 4'h1}, '{3'h7, 8'h40, 4'h7},
                               '{3'h7, 8'h05, 4'h1}};
    logic [7:0]   offs [3] = '{SGS_OFF_CTRL, SGS_OFF_FORCE, SGS_OFF_REMOTE};
    sgs_selector u_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .apb_req_i(req), .apb_rsp_o(rsp),
        .grp_act_i(act), .active_grp_o(grp), .active_onehot_o(onehot), .grp_enabled_o(en),
        .defaults_load_o(dload), .req_fail_o(fail), .force_active_o(frc));
    sgs_act_src u_src (.clock_i(clock_i), .grp_act_o(act));
    // Free-running clock
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    // Hang guard, far above the two hundred or so cycles needed
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            summarize();
        end
    end
    // ****
    // Tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : chk
    // One bus transfer, held until ready is seen
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        req <= {1'b1, 1'b0, w, a, d};
        @(posedge clock_i);
        req.penable <= 1'b1;
        do begin
            @(posedge clock_i);
        end while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask : xfer
    // Settle a few cycles, look between edges
    task automatic wt(input int n);
        repeat (n) @(posedge clock_i);
        @(negedge clock_i);
    endtask : wt
    task automatic summarize();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    // ****
    // Main sequence
    // ****
    initial begin
        sys_rst_i = 1'b1;
        req = '0;
        err_count = 0;
        samples_checked = 0;
        cyc = 0;
        repeat (10) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        // Ordinary selections by pulses
        foreach (rows[i]) begin
            xfer(1'b1, SGS_OFF_CTRL, {25'h0, rows[i].used, 4'h0});
            u_src.pulse(rows[i].act);
            wt(3);
            chk(grp, rows[i].exp);
            chk(onehot, 8'h01 << (rows[i].exp - 4'h1));
            chk(en, 8'hff >> (3'h7 - rows[i].used));
        end
        // Reset in mid-run restores defaults
        @(posedge clock_i);
        sys_rst_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        wt(1);
        chk({frc, en}, {1'b0, SGS_MASK_ONE});
        xfer(1'b0, SGS_OFF_STATUS, 32'h0);
        chk(q, 32'h0000_0101);
        foreach (offs[i]) begin
            xfer(1'b0, offs[i], 32'h0);
            chk(q, 32'h0);
        end
        // Unmapped place answers with an error
        xfer(1'b0, 8'h14, 32'h0);
        chk(q, 32'h0);
        chk({31'h0, e}, 32'h1);
        // Forcing refused while the enable is off, then forced picks once it is on
        xfer(1'b1, SGS_OFF_CTRL, 32'h70);
        wt(1);
        chk(dload, 8'hfe);
        xfer(1'b1, SGS_OFF_FORCE, 32'h5);
        wt(0);
        chk(fail, 1'b1);
        wt(1);
        chk(grp, SGS_GRP_ONE);
        xfer(1'b1, SGS_OFF_CTRL, 32'h71);
        xfer(1'b1, SGS_OFF_FORCE, 32'h6);
        wt(2);
        chk(grp, 4'h6);
        u_src.pulse(8'h02);
        u_src.hold(8'h04);
        wt(2);
        chk(grp, 4'h6);
        xfer(1'b1, SGS_OFF_LOCAL, 32'h4);
        xfer(1'b1, SGS_OFF_CTRL, 32'h31);
        xfer(1'b1, SGS_OFF_FORCE, 32'h8);
        wt(2);
        chk(grp, 4'h4);
        xfer(1'b0, SGS_OFF_STATUS, 32'h0);
        chk(q[18:16], 3'h3);
        xfer(1'b1, SGS_OFF_STATUS, 32'h0007_0000);
        // Release: held level takes control again
        xfer(1'b1, SGS_OFF_CTRL, 32'h70);
        wt(3);
        chk(grp, 4'h3);
        // Held group three blocks lower requests
        xfer(1'b1, SGS_OFF_REMOTE, 32'h5);
        u_src.pulse(8'h24);
        wt(2);
        chk(grp, 4'h3);
        xfer(1'b0, SGS_OFF_STATUS, 32'h0);
        chk(q[18:16], 3'h4);
        // Held group eight blocks nothing
        u_src.hold(8'h80);
        u_src.pulse(8'h20);
        wt(0);
        chk(grp, 4'h6);
        wt(1);
        chk(grp, 4'h8);
        xfer(1'b1, SGS_OFF_REMOTE, 32'h7);
        wt(0);
        chk(grp, 4'h7);
        // Lowering the used code drops back to group one
        xfer(1'b1, SGS_OFF_CTRL, 32'h10);
        wt(2);
        chk(grp, SGS_GRP_ONE);
        // Panel request refused while forcing is off
        xfer(1'b1, SGS_OFF_LOCAL, 32'h2);
        wt(0);
        chk(fail, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
